/* common/dsadc_pkg.sv */
// Constants shared by the dual-slope converter sequencer.
// Assumes a 125 MHz system clock and an AHB-Lite register bus.
package dsadc_pkg;
  // ****************************************************
  // Timing.
  // ****************************************************
  localparam int unsigned CLK_NS       = 8;
  localparam int unsigned UP_PERIOD_MS = 100;
  localparam int unsigned UP_SPAN      = 1000;
  // One converter clock pulse lasts up period over span.
  localparam int unsigned PULSE_NS     =
    (UP_PERIOD_MS * 1000000) / UP_SPAN;
  localparam int unsigned PULSE_CYC    = PULSE_NS / CLK_NS;
  localparam int unsigned DIV_W        = 16;
  // ****************************************************
  // Counter values.
  // ****************************************************
  localparam int unsigned CNT_W        = 11;
  localparam logic [10:0] CNT_PRESET   = 11'h3E8; // 1000
  localparam logic [10:0] CNT_DECODE   = 11'h7CE; // 1998
  localparam logic [10:0] CNT_LAST     = 11'h7CF; // 1999
  localparam logic [10:0] CNT_ZERO     = 11'h000;
  // ****************************************************
  // Register map, byte offsets.
  // ****************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_RESULT    = 8'h08;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST        = 1'b1;
  localparam int unsigned ST_A_BIT     = 0;
  localparam int unsigned ST_B_BIT     = 1;
  localparam int unsigned ST_POL_BIT   = 2;
  localparam int unsigned ST_CNT_LSB   = 16;
  localparam int unsigned RES_POL_BIT  = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

/* common/dsadc_cnt_if.sv */
// Link between the sequencer and its decade counter.
// Assumes both ends run on the same clock.
interface dsadc_cnt_if;
  logic        step;
  logic        gate;
  logic        clear;
  logic [10:0] value;
  logic        at_decode;
  modport ctl (output step, output gate, output clear,
               input value, input at_decode);
  modport cnt (input step, input gate, input clear,
               output value, output at_decode);
endinterface

/* design/dsadc_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes inputs may change at any time relative to clock.
module dsadc_sync #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             reset,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First flop feeds only the second flop.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

  sequence s_two_later;
    ##2 1'b1;
  endsequence
  property p_sync_delay;
    @(posedge clock) disable iff (reset)
    (1'b1 ##0 s_two_later) |-> sync_out == $past(async_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // [RULE18]
    else $error("Synchroniser delay is not two cycles.");
endmodule // dsadc_sync

/* design/dsadc_counter.sv */
// Counter for the converter: presets, counts modulo 2000.
// Assumes step is a one-cycle pulse from the sequencer.
module dsadc_counter (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Sequencer link.
  dsadc_cnt_if.cnt  cnt
);
  logic [10:0] value_r;
  logic [10:0] value_nxt;

  // Next count: clear wins, wrap after the last count.
  always_comb
  begin
    value_nxt = value_r;
    if (cnt.clear)
      value_nxt = dsadc_pkg::CNT_PRESET; // [RULE12]
    else if (cnt.step && cnt.gate)
    begin
      if (value_r == dsadc_pkg::CNT_LAST)
        value_nxt = dsadc_pkg::CNT_ZERO; // [RULE8]
      else
        value_nxt = value_r + 11'h001;
    end
  end

  // Count register.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      value_r <= dsadc_pkg::CNT_PRESET;
    else
      value_r <= value_nxt;
  end

  assign cnt.value     = value_r;
  assign cnt.at_decode = (value_r == dsadc_pkg::CNT_DECODE);

  property p_wrap;
    @(posedge clock) disable iff (reset)
    cnt.step && cnt.gate && !cnt.clear &&
      value_r == dsadc_pkg::CNT_LAST |=> value_r == 11'h000;
  endproperty
  a_wrap: assert property (p_wrap) // [RULE8]
    else $error("Count did not roll from 1999 to 0.");

  property p_preset;
    @(posedge clock) disable iff (reset)
    cnt.clear |=> value_r == 11'h3E8;
  endproperty
  a_preset: assert property (p_preset) // [RULE12]
    else $error("Counter clear did not preset 1000.");

  property p_hold_closed;
    @(posedge clock) disable iff (reset)
    !cnt.gate && !cnt.clear |=> $stable(value_r);
  endproperty
  a_hold_closed: assert property (p_hold_closed) // [RULE10]
    else $error("Counter moved with the gate closed.");
endmodule // dsadc_counter

/* design/dsadc_seq.sv */
// Dual-slope converter sequencer with AHB-Lite registers.
// Assumes comparator and stop pins are asynchronous.
// Contract
// [RULE1] Start only with both phase flops zero and both stops high.
// [RULE2] First phase flop sets on the next clock pulse falling edge.
// [RULE3] Up phase drives integrate control low: integrator charges.
// [RULE4] Counter gate opens with upward integration.
// [RULE5] Counter runs from preset 1000 to 2000: 100 ms up period.
// [RULE6] At count 1998 falling edge latches comparator polarity.
// [RULE7] Same decode event sets the second phase flop.
// [RULE8] Gate stays open; count rolls 1999 to 0, then counts.
// [RULE9] Comparator zero advances phase at next falling edge.
// [RULE10] First phase flop clearing closes the counter gate.
// [RULE11] High half of next pulse copies count to display latch.
// [RULE12] Next pulse goes to reset; clear lines preset 1000.
// [RULE13] Reset restarts automatically unless a stop input is low. The code also holds in reset while the run bit is clear.
// [RULE14] Charging: injection off, both shunt switches on.
// [RULE15] Discharge: injection on, shunt chosen by polarity off.
// [RULE16] Phase strobes decode from both phase flops and complements.
// [RULE17] After zero crossing integrate control stays high.
// [RULE18] Comparator zero passes a synchroniser before use.
module dsadc_seq #(
  parameter int unsigned PULSE_CYCLES = dsadc_pkg::PULSE_CYC
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Comparator and stop pins.
  input  wire logic        comparator_zero,
  input  wire logic        comparator_pol,
  input  wire logic        stop_input_one,
  input  wire logic        stop_input_two,
  // Analog switch drives.
  output logic             integrate_phase_ctl,
  output logic             ref_inject_on,
  output logic             shunt_pos_on,
  output logic             shunt_neg_on,
  output logic             counter_clear_line_one,
  output logic             counter_clear_line_two,
  // Display latch.
  output logic [10:0]      display_value,
  output logic             display_negative
);
  // ****************************************************
  // Synchronised pins.
  // ****************************************************
  logic [3:0] pins_s;
  logic       zero_s;
  logic       pol_s;
  logic       stop1_s;
  logic       stop2_s;

  // All pins pass two flops before any logic.
  dsadc_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({comparator_zero, comparator_pol,
                stop_input_one, stop_input_two}),
    .sync_out (pins_s)
  );
  assign zero_s  = pins_s[3]; // [RULE18]
  assign pol_s   = pins_s[2];
  assign stop1_s = pins_s[1];
  assign stop2_s = pins_s[0];

  // ****************************************************
  // Converter clock pulse.
  // ****************************************************
  logic [15:0] div_r;
  logic        tick_rise;
  logic        tick_fall;

  // Divider forms one converter pulse per PULSE_CYCLES.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      div_r <= 16'h0000;
    else if (div_r == 16'(PULSE_CYCLES - 1))
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end
  assign tick_rise = (div_r == 16'h0000);
  assign tick_fall = (div_r == 16'(PULSE_CYCLES / 2));

  // ****************************************************
  // Registers and phase flops.
  // ****************************************************
  logic       first_phase_flop_r;
  logic       second_phase_flop_r;
  logic       pol_r;
  logic       run_r;
  logic       st_reset;
  logic       st_up;
  logic       st_down;
  logic       st_xfer;
  logic       start_ok;
  dsadc_cnt_if cnt ();

  dsadc_counter u_counter (
    .clock (clock),
    .reset (reset),
    .cnt   (cnt.cnt)
  );

  // Phase strobes from true and complemented flop outputs.
  assign st_reset = !first_phase_flop_r && !second_phase_flop_r; // [RULE16]
  assign st_up    = first_phase_flop_r && !second_phase_flop_r;  // [RULE16]
  assign st_down  = first_phase_flop_r && second_phase_flop_r;   // [RULE16]
  assign st_xfer  = !first_phase_flop_r && second_phase_flop_r;  // [RULE16]
  assign start_ok = stop1_s && stop2_s && run_r; // [RULE1] [RULE13]

  // First phase flop: set from reset, cleared by zero.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      first_phase_flop_r <= 1'b0;
    else if (tick_fall)
    begin
      if (st_reset && start_ok)
        first_phase_flop_r <= 1'b1; // [RULE1] [RULE2] [RULE13]
      else if (st_down && zero_s)
        first_phase_flop_r <= 1'b0; // [RULE9]
    end
  end

  // Second phase flop: set at decode, cleared after transfer.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      second_phase_flop_r <= 1'b0;
    else if (tick_fall)
    begin
      if (st_up && cnt.at_decode)
        second_phase_flop_r <= 1'b1; // [RULE7]
      else if (st_xfer)
        second_phase_flop_r <= 1'b0; // [RULE12]
    end
  end

  // Polarity flop takes the sign at the decode falling edge.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pol_r <= 1'b0;
    else if (tick_fall && st_up && cnt.at_decode)
      pol_r <= pol_s; // [RULE6]
  end

  // Display latch loads in the high half of the pulse.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      display_value    <= dsadc_pkg::CNT_ZERO;
      display_negative <= 1'b0;
    end
    else if (tick_rise && st_xfer)
    begin
      display_value    <= cnt.value; // [RULE11]
      display_negative <= pol_r;
    end
  end

  // Counter link: gate follows the first phase flop.
  assign cnt.step  = tick_rise;
  assign cnt.gate  = first_phase_flop_r; // [RULE4] [RULE10]
  assign cnt.clear = st_reset;           // [RULE5] [RULE12]
  assign counter_clear_line_one = st_reset;
  assign counter_clear_line_two = st_reset;

  // Analog drives: control low only while integrating up.
  assign integrate_phase_ctl = !st_up;              // [RULE3] [RULE17]
  assign ref_inject_on       = integrate_phase_ctl; // [RULE14] [RULE15]
  assign shunt_pos_on = !(integrate_phase_ctl && pol_r);  // [RULE15]
  assign shunt_neg_on = !(integrate_phase_ctl && !pol_r); // [RULE14]

  // ****************************************************
  // AHB-Lite slave: zero wait states, always OKAY.
  // ****************************************************
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       take;

  assign take = hsel && hready &&
    (htrans == dsadc_pkg::HTRANS_NONSEQ ||
     htrans == dsadc_pkg::HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture for writes.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Control register: run enable acts as a third stop.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      run_r <= dsadc_pkg::CTRL_RUN_RST;
    else if (wr_pend_r && wr_addr_r == dsadc_pkg::REG_CTRL)
      run_r <= hwdata[dsadc_pkg::CTRL_RUN_BIT];
  end

  // Read data registered in the address phase.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
    begin
      hrdata <= 32'h00000000;
      case (haddr[7:0])
        dsadc_pkg::REG_CTRL:
          hrdata[dsadc_pkg::CTRL_RUN_BIT] <= run_r;
        dsadc_pkg::REG_STATUS:
        begin
          hrdata[dsadc_pkg::ST_A_BIT]   <= first_phase_flop_r;
          hrdata[dsadc_pkg::ST_B_BIT]   <= second_phase_flop_r;
          hrdata[dsadc_pkg::ST_POL_BIT] <= pol_r;
          hrdata[dsadc_pkg::ST_CNT_LSB +: 11] <= cnt.value;
        end
        dsadc_pkg::REG_RESULT:
        begin
          hrdata[10:0] <= display_value;
          hrdata[dsadc_pkg::RES_POL_BIT] <= display_negative;
        end
        default:
          hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // Checks.
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_start_ok;
    st_reset && start_ok && tick_fall;
  endsequence
  sequence s_decode_fall;
    st_up && cnt.at_decode && tick_fall;
  endsequence
  sequence s_zero_seen;
    st_down && zero_s && tick_fall;
  endsequence

  property p_start_when_ready;
    s_start_ok |=> st_up;
  endproperty
  a_start_when_ready: assert property (p_start_when_ready) // [RULE13]
    else $error("Ready sequencer did not start.");

  property p_start_cause;
    $rose(first_phase_flop_r) |-> $past(st_reset) &&
      $past(start_ok) && $past(tick_fall);
  endproperty
  a_start_cause: assert property (p_start_cause) // [RULE1] [RULE2]
    else $error("Cycle began without start conditions.");

  property p_up_drive;
    st_up |-> !integrate_phase_ctl && cnt.gate &&
      !ref_inject_on && shunt_pos_on && shunt_neg_on;
  endproperty
  a_up_drive: assert property (p_up_drive) // [RULE3] [RULE14]
    else $error("Wrong drives during upward integration.");

  property p_down_drive;
    st_down |-> integrate_phase_ctl && ref_inject_on &&
      (shunt_pos_on != shunt_neg_on) && shunt_neg_on == pol_r;
  endproperty
  a_down_drive: assert property (p_down_drive) // [RULE15]
    else $error("Wrong drives during discharge.");

  property p_decode;
    s_decode_fall |=> st_down && pol_r == $past(pol_s);
  endproperty
  a_decode: assert property (p_decode) // [RULE6] [RULE7]
    else $error("Decode did not latch polarity and phase.");

  property p_zero_adv;
    s_zero_seen |=> st_xfer ##0 !cnt.gate ##0 integrate_phase_ctl;
  endproperty
  a_zero_adv: assert property (p_zero_adv) // [RULE9] [RULE10]
    else $error("Zero crossing did not advance the phase.");

  property p_transfer;
    st_xfer && tick_rise |=> display_value == $past(cnt.value);
  endproperty
  a_transfer: assert property (p_transfer) // [RULE11]
    else $error("Transfer did not load the display latch.");

  property p_back_to_reset;
    st_xfer && tick_fall |=> st_reset ##1 cnt.value == 11'h3E8;
  endproperty
  a_back_to_reset: assert property (p_back_to_reset) // [RULE12]
    else $error("Transfer did not return to a preset reset.");

  property p_up_entry_count;
    $rose(st_up) |-> cnt.value == 11'h3E8;
  endproperty
  a_up_entry_count: assert property (p_up_entry_count) // [RULE5]
    else $error("Upward integration did not start at 1000.");

  property p_strobes_onehot;
    $onehot({st_reset, st_up, st_down, st_xfer});
  endproperty
  a_strobes_onehot: assert property (p_strobes_onehot) // [RULE16]
    else $error("Phase strobes are not one-hot.");

  property p_hold_high;
    st_xfer |-> integrate_phase_ctl && ref_inject_on;
  endproperty
  a_hold_high: assert property (p_hold_high) // [RULE17]
    else $error("Integrator not held after the zero crossing.");
endmodule // dsadc_seq

/* verification/dsadc_analog_model.sv */
// Behavioural integrator and comparator on the converter's far side.
// Assumes one clock; the testbench sets the measured input level.
module dsadc_analog_model (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               reset,
  // Measured input, signed charge units per clock.
  input  wire logic signed [15:0] vin,
  // Switch drives from the sequencer.
  input  wire logic               integrate_phase_ctl,
  input  wire logic               ref_inject_on,
  input  wire logic               shunt_pos_on,
  input  wire logic               shunt_neg_on,
  // Comparator outputs.
  output logic                    comparator_zero,
  output logic                    comparator_pol
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Integrator.
  // ********************
  localparam int REF_STEP = 1000; // Reference charge per clock.
  int charge;
  // Charges with the input while injection is off, else discharges
  // towards zero through the reference whose shunt is open.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      charge <= 0;
    else if (!integrate_phase_ctl && !ref_inject_on)
      charge <= charge + vin;
    else if (ref_inject_on && !shunt_neg_on && shunt_pos_on)
      charge <= (charge > REF_STEP) ? charge - REF_STEP : 0;
    else if (ref_inject_on && !shunt_pos_on && shunt_neg_on)
      charge <= (charge < -REF_STEP) ? charge + REF_STEP : 0;
  end
  // Comparator sees zero and the sign of the stored charge.
  assign comparator_zero = (charge == 0);
  assign comparator_pol  = (charge < 0);
endmodule // dsadc_analog_model

/* verification/test_dual_slope_adc_sequencer.sv */
// Self-checking testbench for the dual-slope converter sequencer.
// Assumes package, design and analog model are compiled first.
module test_dual_slope_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Signals.
  // ********************
  localparam int unsigned P = 8; // Converter pulse in clocks.
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               hsel = 1'b0, hwrite = 1'b0;
  logic               hready, hreadyout, hresp;
  logic        [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        [1:0]  htrans = 2'h0;
  logic        [2:0]  hsize = 3'h2;
  logic               stop_input_one = 1'b0, stop_input_two = 1'b1;
  logic               comparator_zero, comparator_pol;
  logic               integrate_phase_ctl, ref_inject_on;
  logic               shunt_pos_on, shunt_neg_on;
  logic               counter_clear_line_one, counter_clear_line_two;
  logic        [10:0] display_value;
  logic               display_negative;
  logic        [3:0]  sw;
  logic        [2:0]  idle;
  logic signed [15:0] vin = 16'sh0;
  logic        [31:0] rv [4] = '{32'h1, 32'h03E80000, 32'h0, 32'h0};
  int                 bad_count = 0, checks = 0, i;
  // Clock with an 8 ns period; the one slave drives hready.
  always #4 clock = ~clock;
  assign hready = hreadyout;
  assign sw = {ref_inject_on, shunt_pos_on, shunt_neg_on,
               counter_clear_line_one};
  assign idle = {integrate_phase_ctl, counter_clear_line_one,
                 counter_clear_line_two};
  // Design and the analog side it drives.
  dsadc_seq #(.PULSE_CYCLES(P)) dut_u (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hreadyout, .hresp, .hrdata, .comparator_zero,
    .comparator_pol, .stop_input_one, .stop_input_two,
    .integrate_phase_ctl, .ref_inject_on, .shunt_pos_on, .shunt_neg_on,
    .counter_clear_line_one, .counter_clear_line_two, .display_value,
    .display_negative
  );
  dsadc_analog_model model_u (
    .clock, .reset, .vin, .integrate_phase_ctl, .ref_inject_on,
    .shunt_pos_on, .shunt_neg_on, .comparator_zero, .comparator_pol
  );
  // ********************
  // Tasks.
  // ********************
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Counts and reports one mismatch.
  task automatic miss(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  // Compares a vector exactly.
  task automatic check_vec(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp)
      miss(m);
  endtask
  // Compares a count with a few pulses of slack.
  task automatic check_near(input logic [10:0] got, input int exp,
                            input string m);
    checks++;
    if ($isunknown(got) || got > exp + 5 || got + 5 < exp)
      miss(m);
  endtask
  // A wait ran out: count it and close the run.
  task automatic timeout();
    miss("wait ran out");
    give_verdict();
  endtask
  // Waits for an edge where hready or the control shows lvl.
  task automatic wait_on(input logic bus, lvl, input int lim);
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while ((bus ? hready : integrate_phase_ctl) !== lvl && k < lim);
    if ((bus ? hready : integrate_phase_ctl) !== lvl)
      timeout();
  endtask
  // One single word transfer; read data lands in rd.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsel   <= 1'b1;
    htrans <= dsadc_pkg::HTRANS_NONSEQ;
    wait_on(1'b1, 1'b1, 16);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_on(1'b1, 1'b1, 16);
    check_vec(hresp, 1'b0, "bus response");
    rd = hrdata;
  endtask
  // Expected display count: the magnitude of the charge units per clock.
  function automatic int exp_count(input int v);
    return v < 0 ? -v : v;
  endfunction
  // One whole conversion of input v, checked phase by phase.
  task automatic convert(input int v);
    int n;
    int mag;
    mag = exp_count(v);
    vin <= 16'(v);
    wait_on(1'b0, 1'b1, 4 * P);
    wait_on(1'b0, 1'b0, 3 * P);
    n = 0;
    while (integrate_phase_ctl === 1'b0 && n < 1100 * P)
    begin
      check_vec(sw, 4'b0110, "charging switches");
      n++;
      @(posedge clock);
    end
    check_vec(n >= 998 * P && n <= 1000 * P, 1, "up span");
    check_vec(sw, {1'b1, v >= 0, v < 0, 1'b0}, "drain");
    n = 0;
    while (counter_clear_line_one !== 1'b1 && n < 2100 * P)
    begin
      check_vec(integrate_phase_ctl, 1, "control dropped");
      n++;
      @(posedge clock);
    end
    if (n >= 2100 * P)
      timeout();
    check_vec(idle, 3'b111, "reset phase");
    check_near(display_value, mag, "display");
    check_vec(display_negative, v < 0, "display sign");
    ahb(1'b0, dsadc_pkg::REG_RESULT, 32'h0);
    check_near(rd[10:0], mag, "result count");
    check_vec(rd[16], v < 0, "result sign");
    $display("conversion of %0d done", v);
  endtask
  // ********************
  // Sequence.
  // ********************
  // Reset, registers, stop conditions, then conversions.
  initial
  begin
    void'($urandom(32'hD810));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
    for (i = 0; i < 4; i++)
    begin
      ahb(1'b0, 8'(4 * i), 32'h0);
      check_vec(rd, rv[i], "register reset");
    end
    $display("register test done");
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        ahb(1'b1, dsadc_pkg::REG_CTRL, 32'h0);
      stop_input_one <= i != 0;
      stop_input_two <= i != 1;
      repeat (10 * P)
      begin
        @(posedge clock);
        check_vec(idle, 3'b111, "held in reset");
      end
    end
    $display("stop test done");
    ahb(1'b1, dsadc_pkg::REG_CTRL, 32'h1);
    stop_input_one <= 1'b1;
    stop_input_two <= 1'b1;
    convert(4);
    convert(-300);
    convert(1000);
    // Random levels stay clear of zero: a zero input leaves the comparator
    // at zero from the start, so the count would stop at the roll point.
    convert(int'($urandom_range(700, 10)));
    convert(-int'($urandom_range(700, 10)));
    give_verdict();
  end
endmodule // test_dual_slope_adc_sequencer
